// >>> pdh_pkg.sv
// shared constants for the phy test diagnostic page handler
package pdh_pkg;
	// phy population and index width
	localparam int NUM_PHYS = 4;
	localparam int PHY_IDX_W = 2;
	localparam int BYTE_W = 8;
	localparam int RATE_W = 4;

	// apb register byte addresses
	localparam logic [7:0] ADDR_PAGE_HDR = 8'h00;
	localparam logic [7:0] ADDR_PAGE_BODY = 8'h04;
	localparam logic [7:0] ADDR_CMD = 8'h08;
	localparam logic [7:0] ADDR_RESULT = 8'h0C;
	localparam logic [7:0] ADDR_PHY_ACTIVE = 8'h10;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h14;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;

	// command register fields
	localparam int CMD_PAGE_LSB = 0;
	localparam int CMD_DIR_BIT = 8;

	// result register fields
	localparam int RES_CHECK_BIT = 0;
	localparam int RES_KEY_LSB = 4;
	localparam int RES_ASC_LSB = 8;
	localparam int RES_BUSY_BIT = 16;

	// interrupt status bits
	localparam int IRQ_W = 3;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_ERR = 1;
	localparam int IRQ_PWR = 2;

	// page header contents
	localparam logic [7:0] PAGE_CODE = 8'h3F;
	localparam logic [3:0] PROTO_ID = 4'h6;
	localparam logic [15:0] PAGE_LEN = 16'h001C;

	// test function, pattern and rate codes
	localparam logic [7:0] FN_STOP = 8'h00;
	localparam logic [7:0] FN_TX_PATTERN = 8'h01;
	localparam logic [7:0] PAT_JITTER = 8'h01;
	localparam logic [7:0] PAT_COMPLIANT = 8'h02;
	localparam logic [3:0] RATE_1G5 = 4'h8;
	localparam logic [3:0] RATE_3G0 = 4'h9;
	localparam logic [3:0] RATE_HW_MIN = 4'h8;
	localparam logic [3:0] RATE_HW_MAX = 4'h9;

	// sense reporting codes
	localparam logic [3:0] SK_NONE = 4'h0;
	localparam logic [3:0] SK_ILLEGAL_REQ = 4'h5;
	localparam logic [7:0] ASC_NONE = 8'h00;
	localparam logic [7:0] ASC_INVALID_PARAM = 8'h26;
	localparam logic [7:0] ASC_TEST_IN_PROG = 8'h71;
endpackage : pdh_pkg

// >>> pdh_page_check.sv
// combinational checker for the protocol-specific diagnostic page
`timescale 1ns/10ps
module pdh_page_check (
	// command as written by software
	input wire logic recv_dir,
	input wire logic [7:0] page_code,
	input wire logic [31:0] page_hdr,
	input wire logic [31:0] page_body,
	// present phy state
	input wire logic [pdh_pkg::NUM_PHYS-1:0] phy_active,
	// verdict
	output logic reject,
	output logic [7:0] asc,
	output logic do_start,
	output logic do_stop,
	output logic [pdh_pkg::PHY_IDX_W-1:0] phy_idx,
	output logic [7:0] pattern,
	output logic [pdh_pkg::RATE_W-1:0] rate
);
	// byte n of a little-end packed word
	function automatic logic [7:0] pick(input logic [31:0] w, input int n);
		pick = w[n*pdh_pkg::BYTE_W +: pdh_pkg::BYTE_W];
	endfunction : pick

	logic [7:0] sel_b;
	logic [7:0] fn_b;
	logic hdr_ok;
	logic phy_ok;

	// header and field extraction, bytes 8..31 are reserved and never read
	assign hdr_ok = (pick(page_hdr, 0) == pdh_pkg::PAGE_CODE) &&
		(pick(page_hdr, 1) & 8'h0F) == {4'h0, pdh_pkg::PROTO_ID} && // hi nibble free
		{pick(page_hdr, 2), pick(page_hdr, 3)} == pdh_pkg::PAGE_LEN;
	assign sel_b = pick(page_body, 0); // R04
	assign fn_b = pick(page_body, 1); // R04
	assign pattern = pick(page_body, 2); // R04
	assign rate = pdh_pkg::RATE_W'(pick(page_body, 3)); // R04
	assign phy_idx = sel_b[pdh_pkg::PHY_IDX_W-1:0];
	assign phy_ok = sel_b < 8'(pdh_pkg::NUM_PHYS);

	// first failing check wins; nothing is applied on a reject
	always_comb begin
		reject = 1'b0;
		asc = pdh_pkg::ASC_NONE;
		do_start = 1'b0;
		do_stop = 1'b0;
		if (recv_dir) begin
			if (page_code == pdh_pkg::PAGE_CODE) begin
				reject = 1'b1; // R02
				asc = pdh_pkg::ASC_INVALID_PARAM; // R01
			end
		end else if (page_code != pdh_pkg::PAGE_CODE || !hdr_ok) begin
			reject = 1'b1;
			asc = pdh_pkg::ASC_INVALID_PARAM;
		end else if (!phy_ok) begin
			reject = 1'b1; // R05
			asc = pdh_pkg::ASC_INVALID_PARAM; // R18
		end else if (fn_b == pdh_pkg::FN_STOP) begin
			do_stop = 1'b1;
		end else if (fn_b != pdh_pkg::FN_TX_PATTERN) begin
			reject = 1'b1; // R06
			asc = pdh_pkg::ASC_INVALID_PARAM;
		end else if (phy_active[phy_idx]) begin
			reject = 1'b1; // R11
			asc = pdh_pkg::ASC_TEST_IN_PROG;
		end else if (pattern != pdh_pkg::PAT_JITTER &&
			pattern != pdh_pkg::PAT_COMPLIANT) begin
			reject = 1'b1; // R14
			asc = pdh_pkg::ASC_INVALID_PARAM; // R13
		end else if (rate < pdh_pkg::RATE_HW_MIN ||
			rate > pdh_pkg::RATE_HW_MAX) begin
			reject = 1'b1; // R16
			asc = pdh_pkg::ASC_INVALID_PARAM; // R15
		end else begin
			do_start = 1'b1;
		end
	end
endmodule : pdh_page_check

// >>> pdh_diag_page.sv
// apb-controlled phy test diagnostic page handler
//
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/10ps
// Summary of operation
// R01: page accepted only via send diagnostic
// R02: receive of page 3Fh gives check condition
// R03: client sends code, protocol 6h, length 001Ch
// R04: bytes 4-7 select phy, function, pattern, rate
// R05: nonexistent phy rejected as invalid field
// R06: unsupported function code rejected
// R07: stop on active phy ends test, link reset
// R08: stop on idle phy changes nothing
// R09: start makes idle phy transmit pattern, rate
// R10: received data discarded during test pattern
// R11: start on busy phy gives in-progress error
// R12: power on ends tests, phy reset sequence
// R13: pattern 01h jitter, 02h compliant, rest reserved
// R14: unsupported pattern rejected
// R15: rate 8h is 1.5G, 9h is 3.0G
// R16: rate outside hardware limits rejected
// R17: per-phy active flag kept and updated
// R18: check order fixed, no change on error
module pdh_diag_page (
	// clock, reset and enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// power-on event pin, asynchronous
	input wire logic power_on_evt,
	// phy receive path, same clock
	input wire logic [pdh_pkg::NUM_PHYS-1:0] phy_rx_valid_in,
	output logic [pdh_pkg::NUM_PHYS-1:0] phy_rx_valid_out,
	// phy test control
	output logic [pdh_pkg::NUM_PHYS-1:0] phy_test_active,
	output logic [pdh_pkg::NUM_PHYS-1:0] phy_rx_ignore,
	output logic [8*pdh_pkg::NUM_PHYS-1:0] phy_pattern,
	output logic [pdh_pkg::RATE_W*pdh_pkg::NUM_PHYS-1:0] phy_rate,
	output logic [pdh_pkg::NUM_PHYS-1:0] phy_link_reset,
	output logic [pdh_pkg::NUM_PHYS-1:0] phy_reset_seq,
	// interrupt
	output logic irq
);
	typedef enum logic [0:0] {PDH_IDLE, PDH_EXEC} pdh_state_t;

	pdh_state_t state_reg;
	pdh_state_t state_next;
	logic [31:0] hdr_reg;
	logic [31:0] body_reg;
	logic [7:0] cmd_page_reg;
	logic cmd_dir_reg;
	logic res_check_reg;
	logic [3:0] res_key_reg;
	logic [7:0] res_asc_reg;
	logic [pdh_pkg::IRQ_W-1:0] irq_status_reg;
	logic [pdh_pkg::IRQ_W-1:0] irq_status_next;
	logic [pdh_pkg::IRQ_W-1:0] irq_mask_reg;
	logic [pdh_pkg::IRQ_W-1:0] irq_set;
	logic [pdh_pkg::NUM_PHYS-1:0] active_reg;
	logic pwr_s1_reg;
	logic pwr_s2_reg;
	logic pwr_s3_reg;
	logic por_pending_reg;
	logic pwr_evt;
	logic apb_access;
	logic wr_commit;
	logic cmd_wr;
	logic exec;
	logic chk_reject;
	logic [7:0] chk_asc;
	logic chk_start;
	logic chk_stop;
	logic [pdh_pkg::PHY_IDX_W-1:0] chk_idx;
	logic [7:0] chk_pattern;
	logic [pdh_pkg::RATE_W-1:0] chk_rate;
	logic [31:0] rd_word;
	logic rd_err;

	// address match helper, used by the write decode only
	function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
		hit = (a == r);
	endfunction : hit

	// apb phase decode; writes land on the edge where pready is seen high
	assign apb_access = psel && penable;
	assign wr_commit = apb_access && pready && pwrite;
	assign cmd_wr = wr_commit && hit(paddr, pdh_pkg::ADDR_CMD);
	assign exec = (state_reg == PDH_EXEC);

	pdh_page_check u_check (
		.recv_dir(cmd_dir_reg),
		.page_code(cmd_page_reg),
		.page_hdr(hdr_reg),
		.page_body(body_reg),
		.phy_active(active_reg),
		.reject(chk_reject),
		.asc(chk_asc),
		.do_start(chk_start),
		.do_stop(chk_stop),
		.phy_idx(chk_idx),
		.pattern(chk_pattern),
		.rate(chk_rate)
	);

	// read mux and unmapped-address detection
	always_comb begin
		rd_word = 32'h0000_0000;
		rd_err = 1'b0;
		case (paddr)
			pdh_pkg::ADDR_PAGE_HDR: rd_word = hdr_reg;
			pdh_pkg::ADDR_PAGE_BODY: rd_word = body_reg;
			pdh_pkg::ADDR_CMD: begin
				rd_word[pdh_pkg::CMD_PAGE_LSB +: 8] = cmd_page_reg;
				rd_word[pdh_pkg::CMD_DIR_BIT] = cmd_dir_reg;
			end
			pdh_pkg::ADDR_RESULT: begin
				rd_word[pdh_pkg::RES_CHECK_BIT] = res_check_reg;
				rd_word[pdh_pkg::RES_KEY_LSB +: 4] = res_key_reg;
				rd_word[pdh_pkg::RES_ASC_LSB +: 8] = res_asc_reg;
				rd_word[pdh_pkg::RES_BUSY_BIT] = (state_reg != PDH_IDLE);
			end
			pdh_pkg::ADDR_PHY_ACTIVE:
				rd_word[pdh_pkg::NUM_PHYS-1:0] = active_reg;
			pdh_pkg::ADDR_IRQ_STATUS:
				rd_word[pdh_pkg::IRQ_W-1:0] = irq_status_reg;
			pdh_pkg::ADDR_IRQ_MASK:
				rd_word[pdh_pkg::IRQ_W-1:0] = irq_mask_reg;
			default: rd_err = 1'b1;
		endcase
	end

	// one wait state: pready rises on the second access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (ce) begin
			pready <= apb_access && !pready;
			prdata <= (apb_access && !pready && !pwrite) ?
				rd_word : 32'h0000_0000;
			pslverr <= apb_access && !pready && rd_err;
		end
	end

	// page buffer and command register; the page only enters here
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hdr_reg <= 32'h0000_0000;
			body_reg <= 32'h0000_0000;
			cmd_page_reg <= 8'h00;
			cmd_dir_reg <= 1'b0;
		end else if (ce && wr_commit && state_reg == PDH_IDLE) begin
			if (hit(paddr, pdh_pkg::ADDR_PAGE_HDR))
				hdr_reg <= pwdata;
			if (hit(paddr, pdh_pkg::ADDR_PAGE_BODY))
				body_reg <= pwdata;
			if (hit(paddr, pdh_pkg::ADDR_CMD)) begin
				cmd_page_reg <= pwdata[pdh_pkg::CMD_PAGE_LSB +: 8];
				cmd_dir_reg <= pwdata[pdh_pkg::CMD_DIR_BIT]; // R01
			end
		end
	end

	// interrupt mask
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_mask_reg <= '0;
		end else if (ce && wr_commit && hit(paddr, pdh_pkg::ADDR_IRQ_MASK)) begin
			irq_mask_reg <= pwdata[pdh_pkg::IRQ_W-1:0];
		end
	end

	// command sequencer: the command register write starts one evaluation
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			PDH_IDLE: if (cmd_wr) state_next = PDH_EXEC;
			PDH_EXEC: state_next = PDH_IDLE;
			default: state_next = PDH_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			state_reg <= PDH_IDLE;
		else if (ce)
			state_reg <= state_next;
	end

	// completion status latched once per command
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			res_check_reg <= 1'b0;
			res_key_reg <= pdh_pkg::SK_NONE;
			res_asc_reg <= pdh_pkg::ASC_NONE;
		end else if (ce && exec) begin
			res_check_reg <= chk_reject; // R02
			res_key_reg <= chk_reject ?
				pdh_pkg::SK_ILLEGAL_REQ : pdh_pkg::SK_NONE;
			res_asc_reg <= chk_asc;
		end
	end

	// power-on pin synchroniser; the detector compares the second and third stages
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pwr_s1_reg <= 1'b0;
			pwr_s2_reg <= 1'b0;
			pwr_s3_reg <= 1'b0;
		end else if (ce) begin
			pwr_s1_reg <= power_on_evt;
			pwr_s2_reg <= pwr_s1_reg;
			pwr_s3_reg <= pwr_s2_reg;
		end
	end

	assign pwr_evt = pwr_s2_reg && !pwr_s3_reg;

	// a reset release counts as power on and owes every phy a reset sequence
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			por_pending_reg <= 1'b1;
		else if (ce)
			por_pending_reg <= 1'b0;
	end

	// sticky interrupt causes; a set in the clearing cycle survives
	always_comb begin
		irq_set = '0;
		irq_set[pdh_pkg::IRQ_DONE] = exec;
		irq_set[pdh_pkg::IRQ_ERR] = exec && chk_reject;
		irq_set[pdh_pkg::IRQ_PWR] = pwr_evt;
		irq_status_next = irq_status_reg;
		if (wr_commit && hit(paddr, pdh_pkg::ADDR_IRQ_STATUS))
			irq_status_next = irq_status_reg & ~pwdata[pdh_pkg::IRQ_W-1:0];
		irq_status_next = irq_status_next | irq_set;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status_reg <= '0;
			irq <= 1'b0;
		end else if (ce) begin
			irq_status_reg <= irq_status_next;
			irq <= |(irq_status_next & irq_mask_reg);
		end
	end

	// per-phy test state, pattern selection and receive gating
	genvar gi;
	generate
		for (gi = 0; gi < pdh_pkg::NUM_PHYS; gi++) begin : g_phy
			logic sel;
			logic start;
			logic stop;
			logic [7:0] pat_reg;
			logic [pdh_pkg::RATE_W-1:0] rate_reg;
			logic link_rst_reg;
			logic rst_seq_reg;
			logic rx_out_reg;

			assign sel = exec && !chk_reject &&
				(chk_idx == pdh_pkg::PHY_IDX_W'(gi)); // R18
			assign start = sel && chk_start; // R09
			assign stop = sel && chk_stop && active_reg[gi]; // R08

			// active flag; power on beats any command in the same cycle
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn)
					active_reg[gi] <= 1'b0; // R17
				else if (ce) begin
					if (pwr_evt)
						active_reg[gi] <= 1'b0; // R12
					else if (start)
						active_reg[gi] <= 1'b1; // R17
					else if (stop)
						active_reg[gi] <= 1'b0; // R07
				end
			end

			// pattern and rate captured only when a test starts
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					pat_reg <= 8'h00;
					rate_reg <= '0;
				end else if (ce && start && !pwr_evt) begin
					pat_reg <= chk_pattern; // R13
					rate_reg <= chk_rate; // R15
				end
			end

			// one-cycle reset requests toward the phy layer
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					link_rst_reg <= 1'b0;
					rst_seq_reg <= 1'b0;
				end else if (ce) begin
					link_rst_reg <= stop && !pwr_evt; // R07
					rst_seq_reg <= pwr_evt || por_pending_reg; // R12
				end
			end

			// incoming data is dropped while a test runs
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn)
					rx_out_reg <= 1'b0;
				else if (ce)
					rx_out_reg <= phy_rx_valid_in[gi] && !active_reg[gi]; // R10
			end

			assign phy_test_active[gi] = active_reg[gi];
			assign phy_rx_ignore[gi] = active_reg[gi]; // R10
			assign phy_pattern[gi*8 +: 8] = pat_reg;
			assign phy_rate[gi*pdh_pkg::RATE_W +: pdh_pkg::RATE_W] = rate_reg;
			assign phy_link_reset[gi] = link_rst_reg;
			assign phy_reset_seq[gi] = rst_seq_reg;
			assign phy_rx_valid_out[gi] = rx_out_reg;
		end
	endgenerate
endmodule : pdh_diag_page

// >>> pdh_chk.sv
// concurrent checks on the ports of the page handler
`timescale 1ns/10ps
module pdh_chk (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	// phy side
	input wire logic power_on_evt,
	input wire logic [3:0] phy_rx_valid_out,
	input wire logic [3:0] phy_test_active,
	input wire logic [3:0] phy_rx_ignore,
	input wire logic [3:0] phy_link_reset,
	input wire logic [3:0] phy_reset_seq
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// sync stages plus edge detect fit inside six cycles
	sequence s_all_reset;
		##[1:6] (phy_reset_seq == 4'hF);
	endsequence
	// a command write committed two edges back
	sequence s_cmd_commit;
		$past(psel & penable & pready & pwrite, 2) &&
			($past(paddr, 2) == pdh_pkg::ADDR_CMD);
	endsequence
	AST_RX_DISCARD: assert property (((phy_rx_valid_out & phy_test_active
		& $past(phy_test_active)) == 4'h0)) else $error("rx passed on test phy");
	AST_IGNORE: assert property ((phy_rx_ignore &
		~$past(phy_rx_ignore)) != 4'h0 |-> s_cmd_commit)
		else $error("receiver ignore set without a command");
	AST_LINK_CAUSE: assert property ((phy_link_reset &
		~($past(phy_test_active) | $past(phy_test_active, 2))) == 4'h0)
		else $error("link reset on phy that was not testing");
	AST_LINK_PULSE: assert property (phy_link_reset != 4'h0 |=>
		phy_link_reset == 4'h0) else $error("link reset longer than a cycle");
	AST_PWR_SEQ: assert property ($rose(power_on_evt) |-> s_all_reset)
		else $error("no phy reset after power on");
	AST_PWR_CLEAR: assert property (phy_reset_seq != 4'h0 |->
		##[0:1] phy_test_active == 4'h0) else $error("test survives power on");
	AST_START_CAUSE: assert property ((phy_test_active &
		~$past(phy_test_active)) != 4'h0 |-> s_cmd_commit)
		else $error("test started without a command");
	AST_PREADY_PULSE: assert property (pready |=> !pready)
		else $error("pready held two cycles");
	AST_SLVERR: assert property (pslverr |-> pready)
		else $error("error without ready");
endmodule : pdh_chk
bind pdh_diag_page pdh_chk pdh_chk_inst (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pready(pready), .pslverr(pslverr), .power_on_evt(power_on_evt),
	.phy_rx_valid_out(phy_rx_valid_out), .phy_test_active(phy_test_active),
	.phy_rx_ignore(phy_rx_ignore), .phy_link_reset(phy_link_reset),
	.phy_reset_seq(phy_reset_seq));

// >>> pdh_client.sv
// application client model: builds pages and drives apb transfers
`timescale 1ns/10ps
module pdh_client (
	// clock
	input wire logic pclk,
	// apb master
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	// bus idle from time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
	end
	// request held until pready is sampled high; no fixed latency assumed
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// header, body, then the command word that starts execution
	task automatic send(input logic [7:0] ph, fn, pt, input logic [3:0] rt,
		input logic dir, input logic [7:0] pg);
		logic [31:0] r;
		logic e;
		apb(1'b1, pdh_pkg::ADDR_PAGE_HDR, {pdh_pkg::PAGE_LEN[7:0],
			pdh_pkg::PAGE_LEN[15:8], 4'h0, pdh_pkg::PROTO_ID,
			pdh_pkg::PAGE_CODE}, r, e);
		apb(1'b1, pdh_pkg::ADDR_PAGE_BODY, {4'h0, rt, pt, fn, ph}, r, e);
		apb(1'b1, pdh_pkg::ADDR_CMD, {23'h00_0000, dir, pg}, r, e);
	endtask : send
endmodule : pdh_client

// >>> tb_top.sv
// self-checking bench for the phy test page handler
`timescale 1ns/10ps
module tb_top;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel, penable, pwrite, pready, pslverr, irq, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd, pat;
	logic power_on_evt = 1'b0;
	logic [3:0] rx_in = 4'h0;
	logic [3:0] rx_out, act, ign, lrst, rseq;
	logic [3:0] lr_seen = 4'h0;
	logic [3:0] rs_seen = 4'h0;
	logic clr_seen = 1'b0;
	logic [15:0] rate;
	logic [19:0] bad [8] = '{20'h0_2018, 20'hE_F018, 20'hF_0018, 20'hF_F018,
		20'h0_1008, 20'h0_1038, 20'h0_1017, 20'h0_101A};
	int n_fail = 0;
	int checks_done = 0;
	int cyc = 0;
	always #12.5 pclk = ~pclk;
	pdh_diag_page pdh_diag_page_inst (.pclk(pclk), .presetn(presetn),
		.ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .power_on_evt(power_on_evt),
		.phy_rx_valid_in(rx_in), .phy_rx_valid_out(rx_out),
		.phy_test_active(act), .phy_rx_ignore(ign), .phy_pattern(pat),
		.phy_rate(rate), .phy_link_reset(lrst), .phy_reset_seq(rseq),
		.irq(irq));
	pdh_client pdh_client_inst (.pclk(pclk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));
	// sticky pulse catchers and the hang guard
	always @(posedge pclk) begin
		cyc++;
		lr_seen <= clr_seen ? 4'h0 : (lr_seen | lrst);
		rs_seen <= clr_seen ? 4'h0 : (rs_seen | rseq);
		if (cyc == 20000) begin
			n_fail++;
			end_of_test;
		end
	end
	task automatic end_of_test;
		$display("checks %0d failures %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_of_test
	task automatic chk(input string nm, input logic [31:0] exp, got);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic rw(input logic w, input logic [7:0] a, input logic [31:0] d);
		pdh_client_inst.apb(w, a, d, rd, err);
	endtask : rw
	// one-cycle request to empty both pulse catchers
	task automatic clr;
		@(posedge pclk) clr_seen <= 1'b1;
		@(posedge pclk) clr_seen <= 1'b0;
	endtask : clr
	// issue a command, then judge result word and active mask
	task automatic cmd(input logic [7:0] ph, fn, pt, input logic [3:0] rt,
		input logic dir, input logic [7:0] pg, asc, input logic [3:0] ea);
		logic [31:0] e;
		e = (asc == 8'h00) ? 32'h0000_0000 :
			{16'h0000, asc, pdh_pkg::SK_ILLEGAL_REQ, 4'h1};
		pdh_client_inst.send(ph, fn, pt, rt, dir, pg);
		rw(1'b0, pdh_pkg::ADDR_RESULT, 32'h0000_0000);
		chk("result", e, rd);
		rw(1'b0, pdh_pkg::ADDR_PHY_ACTIVE, 32'h0000_0000);
		chk("active", {28'h000_0000, ea}, rd);
	endtask : cmd
	// refusals must leave every phy idle
	task automatic t_reject;
		cmd(8'h00, 8'h00, 8'h00, 4'h0, 1'b1, 8'h3F, 8'h26, 4'h0);
		cmd(8'h00, 8'h00, 8'h00, 4'h0, 1'b1, 8'h00, 8'h00, 4'h0);
		cmd(8'h04, 8'h01, 8'h01, 4'h8, 1'b0, 8'h3F, 8'h26, 4'h0);
		foreach (bad[i])
			cmd(8'h00, bad[i][19:12], bad[i][11:4], bad[i][3:0], 1'b0,
				8'h3F, 8'h26, 4'h0);
	endtask : t_reject
	task automatic t_start_stop;
		cmd(8'h00, 8'h01, 8'h01, 4'h8, 1'b0, 8'h3F, 8'h00, 4'h1);
		cmd(8'h02, 8'h01, 8'h02, 4'h9, 1'b0, 8'h3F, 8'h00, 4'h5);
		chk("pattern", 32'h0002_0001, pat);
		chk("rate", 32'h0000_0908, {16'h0000, rate});
		chk("ignore", 32'h0000_0005, {28'h000_0000, ign});
		@(posedge pclk) rx_in <= 4'hF;
		repeat (3) @(posedge pclk);
		chk("rx out", 32'h0000_000A, {28'h000_0000, rx_out});
		rx_in <= 4'h0;
		cmd(8'h00, 8'h01, 8'h01, 4'h8, 1'b0, 8'h3F, 8'h71, 4'h5);
		clr;
		cmd(8'h01, 8'h00, 8'h00, 4'h0, 1'b0, 8'h3F, 8'h00, 4'h5);
		chk("link reset", 32'h0000_0000, {28'h000_0000, lr_seen});
		cmd(8'h00, 8'h00, 8'h00, 4'h0, 1'b0, 8'h3F, 8'h00, 4'h4);
		chk("link reset", 32'h0000_0001, {28'h000_0000, lr_seen});
	endtask : t_start_stop
	// done and error are pending from earlier commands
	task automatic t_irq;
		rw(1'b0, pdh_pkg::ADDR_IRQ_MASK, 32'h0000_0000);
		chk("mask reset", 32'h0000_0000, rd);
		rw(1'b0, pdh_pkg::ADDR_IRQ_STATUS, 32'h0000_0000);
		chk("status", 32'h0000_0003, rd & 32'h0000_0003);
		chk("irq masked", 32'h0000_0000, {31'h0000_0000, irq});
		rw(1'b1, pdh_pkg::ADDR_IRQ_MASK, 32'h0000_0003);
		repeat (2) @(posedge pclk);
		chk("irq", 32'h0000_0001, {31'h0000_0000, irq});
		rw(1'b1, pdh_pkg::ADDR_IRQ_STATUS, 32'h0000_0007);
		rw(1'b0, pdh_pkg::ADDR_IRQ_STATUS, 32'h0000_0000);
		chk("status clr", 32'h0000_0000, rd);
		chk("irq clr", 32'h0000_0000, {31'h0000_0000, irq});
		rw(1'b0, 8'h1C, 32'h0000_0000);
		chk("unmapped", 32'h0000_0001, {rd[30:0], err});
	endtask : t_irq
	// phy 2 is still testing when power returns
	task automatic t_power;
		clr;
		@(posedge pclk) power_on_evt <= 1'b1;
		repeat (8) @(posedge pclk);
		power_on_evt <= 1'b0;
		chk("reset seq", 32'h0000_000F, {28'h000_0000, rs_seen});
		chk("active", 32'h0000_0000, {28'h000_0000, act});
		rw(1'b0, pdh_pkg::ADDR_IRQ_STATUS, 32'h0000_0000);
		chk("status pwr", 32'h0000_0004, rd);
	endtask : t_power
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		t_reject;
		t_start_stop;
		t_irq;
		t_power;
		end_of_test;
	end
endmodule : tb_top
